// ### src/i2c_slave_map_access_port.sv
`timescale 1ns/10ps
module i2c_slave_map_access_port
    import i2c_map_pkg::*;
(
    // clock and reset
    input  wire logic       CLOCK_I,
    input  wire logic       SRST_I,
    // two-wire bus pins
    input  wire logic       SCL_I,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE_O,
    // strap
    input  wire logic       ADDRESS_SELECT_PIN_I,
    // register-map side for all maps but the three local registers
    output logic [2:0]      MAP_SEL_O,
    output logic [7:0]      REG_ADDR_O,
    output logic [7:0]      WR_DATA_O,
    output logic            WR_STB_O,
    input  wire logic [7:0] RD_DATA_I,
    input  wire logic       ADDR_VALID_I,
    // local register contents
    output logic [1:0]      SUBMAP_SELECT_FIELD_O
);
    import i2c_map_pkg::*;

    // ------------------------------------------------------------------
    // types and state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_ACK   = 3'b011,
        ST_SUB   = 3'b010,
        ST_WDATA = 3'b110,
        ST_RDATA = 3'b111,
        ST_RACK  = 3'b101
    } state_type;

    state_type  state;          // protocol position
    state_type  after_ack;      // where to go once the ack bit ends
    logic       scl_s;          // synchronised clock line
    logic       sda_s;          // synchronised data line
    logic       scl_d;          // previous clock sample
    logic       sda_d;          // previous data sample
    logic [3:0] bit_cnt;        // bits of the current byte
    logic [7:0] shift;          // incoming byte
    logic [7:0] tx;             // outgoing byte
    logic       is_read;        // direction of this transfer
    logic       ack_drive;      // hold data line low for ack
    logic       at_top;         // subaddress has hit the highest one
    logic [7:0] subaddr;        // current register subaddress
    logic [2:0] cur_map;        // map addressed in this transfer
    logic [7:0] submap_ctrl;    // local sub-map register
    logic [7:0] postproc_addr;  // local postprocessor address register
    logic [7:0] serial_addr;    // local serial output address register
    logic [7:0] rd_mux;         // byte to send at current subaddress
    logic       sub_valid;      // current subaddress exists
    logic       dec_hit;        // address byte matched
    logic [2:0] dec_map;        // map for matched address
    logic [7:0] byte_in;        // completed byte including last bit
    logic       local_reg;      // subaddress is one of ours
    logic       sub_ack;        // ack pending is for a subaddress
    logic       addr_sel_s;     // synchronised strap

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    line_sync u_scl_sync (
        .CLOCK_I (CLOCK_I),
        .SRST_I  (SRST_I),
        .line_i  (SCL_I),
        .line_o  (scl_s)
    );
    line_sync u_sda_sync (
        .CLOCK_I (CLOCK_I),
        .SRST_I  (SRST_I),
        .line_i  (SDA_I),
        .line_o  (sda_s)
    );
    line_sync u_sel_sync (
        .CLOCK_I (CLOCK_I),
        .SRST_I  (SRST_I),
        .line_i  (ADDRESS_SELECT_PIN_I),
        .line_o  (addr_sel_s)
    );

    // edge history of the synchronised lines
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_d;                    // sample point
    wire scl_fall = ~scl_s & scl_d;                    // drive point
    wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;    // end of transfer

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    map_decode u_decode (
        .addr_i            (byte_in[7:1]),
        .addr_sel_i        (addr_sel_s),
        .submap_i          (submap_ctrl[SUBMAP_FIELD_MSB:SUBMAP_FIELD_LSB]),
        .postproc_addr_i   (postproc_addr[7:1]),
        .serial_out_addr_i (serial_addr[7:1]),
        .hit_o             (dec_hit),
        .map_o             (dec_map)
    );

    // byte as it stands once the current rising edge is shifted in
    assign byte_in = {shift[6:0], sda_s};

    // sub-map select stays reachable from every main sub map
    assign local_reg = (cur_map <= MAP_GENERAL2 && subaddr == SUBMAP_SELECT_CTRL_OFS) ||
                       (cur_map == MAP_GENERAL &&
                        (subaddr == POSTPROC_MAP_SLAVE_ADDR_OFS ||
                         subaddr == SERIAL_OUT_MAP_SLAVE_ADDR_OFS));

    // ------------------------------------------------------------------
    // read data mux and subaddress validity
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux    = RD_DATA_I;
        sub_valid = ADDR_VALID_I;
        if (local_reg) begin
            sub_valid = 1'b1;
            if (subaddr == SUBMAP_SELECT_CTRL_OFS) begin
                rd_mux = submap_ctrl;
            end else if (subaddr == POSTPROC_MAP_SLAVE_ADDR_OFS) begin
                rd_mux = postproc_addr;
            end else begin
                rd_mux = serial_addr;
            end
        end
    end

    // ------------------------------------------------------------------
    // protocol state machine
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            state     <= ST_IDLE;
            after_ack <= ST_IDLE;
            bit_cnt   <= 4'h0;
            shift     <= 8'h00;
            is_read   <= 1'b0;
            ack_drive <= 1'b0;
            cur_map   <= MAP_GENERAL;
            subaddr   <= 8'h00;
            at_top    <= 1'b0;
            sub_ack   <= 1'b0;
        end else if (start_c) begin
            // any start, repeated or stray, begins a fresh address phase
            state     <= ST_ADDR;
            bit_cnt   <= 4'h0;
            ack_drive <= 1'b0;
        end else if (stop_c) begin
            state     <= ST_IDLE;
            ack_drive <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    ack_drive <= 1'b0;
                end
                ST_ADDR, ST_SUB, ST_WDATA: begin
                    if (scl_rise) begin
                        shift   <= byte_in;
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
                            bit_cnt <= 4'h0;
                            state   <= ST_ACK;
                            sub_ack <= (state == ST_SUB);
                            if (state == ST_ADDR) begin
                                // first byte is the device address
                                is_read   <= byte_in[0];
                                cur_map   <= dec_map;
                                ack_drive <= dec_hit;
                                after_ack <= !dec_hit ? ST_IDLE :
                                             byte_in[0] ? ST_RDATA : ST_SUB;
                            end else if (state == ST_SUB) begin
                                // second byte is the starting subaddress
                                subaddr   <= byte_in;
                                at_top    <= 1'b0;
                                ack_drive <= 1'b1;
                                after_ack <= ST_WDATA;
                            end else begin
                                // write beyond the top is dropped
                                ack_drive <= sub_valid && !at_top;
                                after_ack <= (sub_valid && !at_top) ? ST_WDATA : ST_IDLE;
                                if (subaddr == HIGHEST_SUBADDR) begin
                                    at_top <= 1'b1;
                                end else begin
                                    subaddr <= subaddr + 8'h01;
                                end
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (sub_ack && !sub_valid) begin
                        ack_drive <= 1'b0;
                        after_ack <= ST_IDLE;
                    end
                    // ack held through the ninth pulse, released on its fall
                    if (scl_fall && scl_d && bit_cnt == 4'h1) begin
                        ack_drive <= 1'b0;
                        state     <= after_ack;
                        bit_cnt   <= 4'h0;
                    end else if (scl_rise) begin
                        bit_cnt <= 4'h1;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
                            bit_cnt <= 4'h0;
                            state   <= ST_RACK;
                            // last register repeats beyond the top
                            if (subaddr != HIGHEST_SUBADDR) begin
                                subaddr <= subaddr + 8'h01;
                            end
                        end
                    end
                end
                ST_RACK: begin
                    // master not-acknowledge ends the read
                    if (scl_rise) begin
                        state <= sda_s ? ST_IDLE : ST_RDATA;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read shifter: loads and shifts on falling clock only
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            tx <= 8'hFF;
        end else if (scl_fall) begin
            if (state == ST_ACK && after_ack == ST_RDATA) begin
                tx <= rd_mux;
            end else if (state == ST_RACK) begin
                tx <= rd_mux;
            end else if (state == ST_RDATA && bit_cnt != 4'h0) begin
                tx <= {tx[6:0], 1'b1};
            end
        end
    end

    // ------------------------------------------------------------------
    // data line drive, open drain: only ever pulls low
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            SDA_OE_O <= 1'b0;
        end else if (start_c || stop_c) begin
            SDA_OE_O <= 1'b0;
        end else if (scl_fall) begin
            // changes at falling edges keep data stable while clock high
            if (state == ST_ACK) begin
                SDA_OE_O <= (after_ack == ST_RDATA) ? ~rd_mux[7] : 1'b0;
            end else if (state == ST_RDATA) begin
                SDA_OE_O <= (bit_cnt == 4'h0) ? ~tx[7] : ~tx[6];
            end else if (state == ST_RACK) begin
                SDA_OE_O <= 1'b0;
            end else begin
                SDA_OE_O <= 1'b0;
            end
        end else if (state == ST_ACK && ack_drive && !scl_s && bit_cnt == 4'h0) begin
            SDA_OE_O <= 1'b1;
        end else if (state == ST_IDLE) begin
            SDA_OE_O <= 1'b0;
        end
    end
    assign SDA_O = 1'b0;

    // ------------------------------------------------------------------
    // register writes: local registers and external strobe
    // ------------------------------------------------------------------
    wire wr_fire = (state == ST_WDATA) && !start_c && !stop_c && scl_rise &&
                   (bit_cnt == BITS_PER_BYTE - 4'h1) && sub_valid && !at_top;

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            submap_ctrl   <= SUBMAP_CTRL_RESET;
            postproc_addr <= POSTPROC_RESET;
            serial_addr   <= SERIAL_OUT_RESET;
        end else if (wr_fire && local_reg) begin
            if (subaddr == SUBMAP_SELECT_CTRL_OFS) begin
                submap_ctrl <= byte_in;
            end else if (subaddr == POSTPROC_MAP_SLAVE_ADDR_OFS) begin
                postproc_addr <= byte_in;
            end else begin
                serial_addr <= byte_in;
            end
        end
    end

    // external write strobe and held data; REG_ADDR_O has already stepped to the next subaddress, except after a write at HIGHEST_SUBADDR
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            WR_STB_O  <= 1'b0;
            WR_DATA_O <= 8'h00;
        end else begin
            WR_STB_O <= wr_fire && !local_reg;
            if (wr_fire) begin
                WR_DATA_O <= byte_in;
            end
        end
    end

    assign MAP_SEL_O             = cur_map;
    assign REG_ADDR_O            = subaddr;
    assign SUBMAP_SELECT_FIELD_O = submap_ctrl[SUBMAP_FIELD_MSB:SUBMAP_FIELD_LSB];

endmodule // i2c_slave_map_access_port

// ### src/i2c_map_pkg.sv
package i2c_map_pkg;

    // ------------------------------------------------------------------
    // main slave address, bit 1 comes from the address-select pin
    // ------------------------------------------------------------------
    localparam logic [6:0] MAIN_ADDR_BASE    = 7'h20;  // 0x40 >> 1
    localparam int         MAIN_ADDR_PIN_BIT = 0;      // bit 1 of the byte = bit 0 of 7-bit addr

    // ------------------------------------------------------------------
    // register offsets inside the main map
    // ------------------------------------------------------------------
    localparam logic [7:0] SUBMAP_SELECT_CTRL_OFS        = 8'h0E;
    localparam logic [7:0] POSTPROC_MAP_SLAVE_ADDR_OFS   = 8'hFD;
    localparam logic [7:0] SERIAL_OUT_MAP_SLAVE_ADDR_OFS = 8'hFE;
    localparam logic [7:0] HIGHEST_SUBADDR               = 8'hFF;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int         SUBMAP_FIELD_LSB   = 5;
    localparam int         SUBMAP_FIELD_MSB   = 6;
    localparam logic [7:0] SUBMAP_CTRL_RESET  = 8'h00;
    localparam logic [7:0] POSTPROC_RESET     = 8'h00;
    localparam logic [7:0] SERIAL_OUT_RESET   = 8'h00;

    // ------------------------------------------------------------------
    // map selection codes
    // ------------------------------------------------------------------
    localparam logic [1:0] SUBMAP_GENERAL   = 2'h0;
    localparam logic [1:0] SUBMAP_INTERRUPT = 2'h1;
    localparam logic [1:0] SUBMAP_GENERAL2  = 2'h2;
    localparam logic [2:0] MAP_GENERAL      = 3'h0;
    localparam logic [2:0] MAP_INTERRUPT    = 3'h1;
    localparam logic [2:0] MAP_GENERAL2     = 3'h2;
    localparam logic [2:0] MAP_POSTPROC     = 3'h3;
    localparam logic [2:0] MAP_SERIAL_OUT   = 3'h4;

    // ------------------------------------------------------------------
    // bit counts
    // ------------------------------------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage

// ### src/line_sync.sv
`timescale 1ns/10ps
module line_sync (
    // clock and reset
    input  wire logic CLOCK_I,
    input  wire logic SRST_I,
    // raw line and synchronised copy
    input  wire logic line_i,
    output logic      line_o
);
    logic first;  // read only by the second stage
    // --------------------------------------------------------------
    // two-stage synchroniser, idle level of the bus is high
    // --------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            first  <= 1'b1;
            line_o <= 1'b1;
        end else begin
            first  <= line_i;
            line_o <= first;
        end
    end
endmodule // line_sync

// ### src/map_decode.sv
`timescale 1ns/10ps
module map_decode
    import i2c_map_pkg::*;
(
    // address under test and configuration
    input  wire logic [6:0] addr_i,
    input  wire logic       addr_sel_i,
    input  wire logic [1:0] submap_i,
    input  wire logic [6:0] postproc_addr_i,
    input  wire logic [6:0] serial_out_addr_i,
    // result
    output logic            hit_o,
    output logic [2:0]      map_o
);
    logic [6:0] main_addr;  // pin-dependent main address
    // --------------------------------------------------------------
    // address match; zero programmed address never matches
    // --------------------------------------------------------------
    always_comb begin
        main_addr = MAIN_ADDR_BASE;
        main_addr[MAIN_ADDR_PIN_BIT] = addr_sel_i;
        hit_o = 1'b0;
        map_o = MAP_GENERAL;
        if (addr_i == main_addr) begin
            hit_o = 1'b1;
            // selected sub map, reserved code falls back to general
            unique case (submap_i)
                SUBMAP_INTERRUPT: map_o = MAP_INTERRUPT;
                SUBMAP_GENERAL2:  map_o = MAP_GENERAL2;
                default:          map_o = MAP_GENERAL;
            endcase
        end else if (postproc_addr_i != 7'h00 && addr_i == postproc_addr_i) begin
            hit_o = 1'b1;
            map_o = MAP_POSTPROC;
        end else if (serial_out_addr_i != 7'h00 && addr_i == serial_out_addr_i) begin
            hit_o = 1'b1;
            map_o = MAP_SERIAL_OUT;
        end
    end
endmodule // map_decode

// ### bench/i2c_slave_map_access_port_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------------------------
// port checker, sees only the top module's ports
// ----------------------------------------------------------
module i2c_port_checker
    import i2c_map_pkg::*;
(
    // clock and reset
    input wire logic       CLOCK_I,
    input wire logic       SRST_I,
    // bus pins
    input wire logic       SCL_I,
    input wire logic       SDA_I,
    input wire logic       SDA_O,
    input wire logic       SDA_OE_O,
    // map side
    input wire logic [2:0] MAP_SEL_O,
    input wire logic       WR_STB_O,
    input wire logic [1:0] SUBMAP_SELECT_FIELD_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);
    // open drain: only ever pulls low
    chk_drive_low: assert property (SDA_O == 1'b0)
        else $error("data pin driven high");
    chk_reset_clear: assert property ($fell(SRST_I) |-> !SDA_OE_O && !WR_STB_O
        && SUBMAP_SELECT_FIELD_O == SUBMAP_GENERAL) else $error("reset state wrong");
    // sync latency is three clocks, so the cause is a clock-low seen earlier
    chk_oe_clock_low: assert property ($changed(SDA_OE_O) |-> !$past(SCL_I, 3))
        else $error("data drive changed in clock high");
    chk_strobe_pulse: assert property (WR_STB_O |=> !WR_STB_O)
        else $error("write strobe longer than one cycle");
    chk_strobe_ack: assert property (WR_STB_O |-> !SDA_OE_O ##[2:20] SDA_OE_O)
        else $error("written byte not acknowledged");
    chk_ack_hold: assert property ($rose(SDA_OE_O) |-> SDA_OE_O [*5])
        else $error("acknowledge too short");
    chk_stop_idle: assert property (SCL_I && $past(SCL_I) && $rose(SDA_I)
        |-> (!WR_STB_O && !SDA_OE_O) [*8]) else $error("activity after stop");
    chk_map_range: assert property (MAP_SEL_O <= MAP_SERIAL_OUT)
        else $error("map select out of range");
    chk_submap_ack: assert property ($changed(SUBMAP_SELECT_FIELD_O)
        |-> ##[1:20] SDA_OE_O) else $error("sub-map write not acknowledged");
    // main scenarios reached
    cov_strobe: cover property (WR_STB_O);
    cov_ack: cover property ($rose(SDA_OE_O));
    cov_submap: cover property ($changed(SUBMAP_SELECT_FIELD_O));
endmodule // i2c_port_checker

// ### bench/i2c_bus_master_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------
// two-wire master, clock stands high between frames
// ----------------------------------------------------------
module i2c_bus_master_model (
    // resolved data line
    input  wire logic sda_i,
    // driven lines, high means released
    output logic      scl_o,
    output logic      sda_o
);
    initial begin // idle with both lines released
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // start or repeated start, one condition per clock high
    task automatic start();
        #45 sda_o = 1'b1;
        #50 scl_o = 1'b1;
        #50 sda_o = 1'b0;
        #50 scl_o = 1'b0;
        #5;
    endtask
    // stop closes every transfer
    task automatic stop();
        #45 sda_o = 1'b0;
        #50 scl_o = 1'b1;
        #50 sda_o = 1'b1;
        #55;
    endtask
    // 160 ns bit, every edge kept clear of the system clock edges
    task automatic bit_xfer(input logic b, output logic s);
        #45 sda_o = b;
        #50 scl_o = 1'b1;
        #60 s = sda_i;
        scl_o = 1'b0;
        #5;
    endtask
    // byte msb first, ninth pulse returns the acknowledge
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], s);
        end
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask
    // byte in; leaving data high on the ninth pulse ends a read
    task automatic recv(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            b[i] = s;
        end
        bit_xfer(last, s);
    endtask
endmodule // i2c_bus_master_model

// ### bench/i2c_slave_map_access_port_test.sv
`timescale 1ns/10ps
module i2c_slave_map_access_port_test;
    import i2c_map_pkg::*;
    // ------------------------------------------------------
    // signals
    // ------------------------------------------------------
    logic       clock = 1'b0;  // 50 MHz
    logic       srst  = 1'b1;  // held for 12 cycles
    logic       pin   = 1'b0;  // address strap
    wire logic  scl, sda_m, oe, sda_o, wr_stb, valid;
    wire logic  sda_line = sda_m & ~oe;  // pull-up wire
    wire logic [2:0] map_sel;
    wire logic [7:0] reg_addr, wr_data, rd_data;
    wire logic [1:0] submap;
    logic [7:0] st_addr, st_data, acks, got;  // last strobe seen
    logic [7:0] n_stb = 8'h00;                // strobe count
    logic [2:0] st_map;
    logic       ack;
    int         miscompares = 0;
    int         n_compared = 0;
    always #10 clock = ~clock;
    // register map beyond the block: subaddress 0x50 is a hole
    assign rd_data = reg_addr ^ {map_sel, 5'h0B};
    assign valid   = reg_addr != 8'h50;
    always @(posedge clock) begin // capture writes
        if (wr_stb === 1'b1) begin
            n_stb   <= n_stb + 8'h01;
            st_map  <= map_sel;
            st_addr <= reg_addr;
            st_data <= wr_data;
        end
    end
    i2c_slave_map_access_port i2c_slave_map_access_port_inst (.CLOCK_I(clock), .SRST_I(srst),
        .SCL_I(scl), .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE_O(oe),
        .ADDRESS_SELECT_PIN_I(pin), .MAP_SEL_O(map_sel), .REG_ADDR_O(reg_addr),
        .WR_DATA_O(wr_data), .WR_STB_O(wr_stb), .RD_DATA_I(rd_data),
        .ADDR_VALID_I(valid), .SUBMAP_SELECT_FIELD_O(submap));
    i2c_bus_master_model i2c_bus_master_model_inst (.sda_i(sda_line), .scl_o(scl),
        .sda_o(sda_m));
    // ------------------------------------------------------
    // tasks
    // ------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // local 0xFE holds 0x88 once programmed; the rest comes from the map
    function automatic logic [7:0] expv(input logic [2:0] mp, input logic [7:0] a);
        return (mp == MAP_GENERAL && a == 8'hFE) ? 8'h88 : a ^ {mp, 5'h0B};
    endfunction
    // write transfer: n bytes d, d+1, ...; stops after the first refusal
    task automatic wr(input logic [6:0] a, input logic [7:0] s, input logic [7:0] d,
                      input int n);
        acks = 8'h00;
        i2c_bus_master_model_inst.start();
        i2c_bus_master_model_inst.send({a, 1'b0}, acks[0]);
        if (acks[0]) i2c_bus_master_model_inst.send(s, acks[1]);
        for (int i = 0; i < n; i++) begin
            if (acks[i+1]) i2c_bus_master_model_inst.send(d + 8'(i), acks[i+2]);
        end
        i2c_bus_master_model_inst.stop();
    endtask
    // read transfer of n bytes from the current subaddress, checked against s onward, capped at the top
    task automatic rd(input logic [6:0] a, input logic [2:0] mp, input logic [7:0] s,
                      input int n);
        i2c_bus_master_model_inst.start();
        i2c_bus_master_model_inst.send({a, 1'b1}, ack);
        check("read address ack", 8'h01, {7'h00, ack});
        for (int i = 0; i < n; i++) begin
            i2c_bus_master_model_inst.recv(i == n - 1, got);
            check("read data", expv(mp, (int'(s) + i > 255) ? 8'hFF : s + 8'(i)), got);
        end
        i2c_bus_master_model_inst.stop();
    endtask
    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------
    // sequence
    // ------------------------------------------------------
    initial begin // watchdog at 20k cycles, the run needs about 5.4k
        #400000;
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        repeat (3) @(posedge clock);
        check("submap after reset", 8'h00, {6'h00, submap});
        wr(7'h21, 8'h10, 8'hA5, 2); check("foreign address", 8'h00, acks);
        wr(7'h20, 8'h10, 8'hA5, 2); check("burst acks", 8'h0F, acks);
        check("burst last addr", 8'h12, st_addr);
        check("burst last data", 8'hA6, st_data);
        @(posedge clock) pin <= 1'b1;
        wr(7'h20, 8'h20, 8'h3C, 1); check("low address with pin", 8'h00, acks);
        wr(7'h21, 8'h20, 8'h3C, 1); check("high address with pin", 8'h07, acks);
        wr(7'h21, 8'h50, 8'h11, 1); check("invalid subaddress", 8'h01, acks);
        check("no strobe on invalid", 8'h03, n_stb);
        wr(7'h21, 8'hFF, 8'h77, 2); check("write overrun", 8'h07, acks);
        check("overrun discarded", 8'h04, n_stb);
        check("top register data", 8'h77, st_data);
        // stray repeated start abandons the write
        i2c_bus_master_model_inst.start();
        i2c_bus_master_model_inst.send(8'h42, ack);
        i2c_bus_master_model_inst.send(8'h10, ack);
        i2c_bus_master_model_inst.start();
        i2c_bus_master_model_inst.send(8'h66, ack); check("idle after restart", 8'h00, {7'h00, ack});
        i2c_bus_master_model_inst.stop(); check("no strobe after restart", 8'h04, n_stb);
        for (int c = 1; c <= 3; c++) begin // sub-map codes, then back to general
            wr(7'h21, 8'h0E, 8'((c % 3) << 5), 1); check("submap field", 8'(c % 3), {6'h00, submap});
            wr(7'h21, 8'h30, 8'h5A, 1); check("write map", 8'(c % 3), {5'h00, st_map});
        end
        wr(7'h42, 8'h00, 8'h00, 0); check("postproc closed", 8'h00, acks);
        wr(7'h44, 8'h00, 8'h00, 0); check("serial out closed", 8'h00, acks);
        wr(7'h21, 8'hFD, 8'h84, 1); wr(7'h21, 8'hFE, 8'h88, 1); wr(7'h21, 8'h0E, 8'h20, 1);
        @(posedge clock) pin <= 1'b0;
        for (int k = 0; k < 2; k++) begin // extra maps ignore pin and sub-map field
            wr(k ? 7'h44 : 7'h42, 8'h20, 8'h99, 1); check("extra map acks", 8'h07, acks);
            check("extra map sel", k ? 8'h04 : 8'h03, {5'h00, st_map});
            rd(k ? 7'h44 : 7'h42, k ? MAP_SERIAL_OUT : MAP_POSTPROC, 8'h21, 2);
        end
        wr(7'h20, 8'h0E, 8'h00, 1); wr(7'h20, 8'hFE, 8'h00, 0);
        rd(7'h20, MAP_GENERAL, 8'hFE, 3);
        complete_run();
    end
endmodule // i2c_slave_map_access_port_test
bind i2c_slave_map_access_port i2c_port_checker i2c_port_checker_inst (.CLOCK_I(CLOCK_I),
    .SRST_I(SRST_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
    .MAP_SEL_O(MAP_SEL_O), .WR_STB_O(WR_STB_O), .SUBMAP_SELECT_FIELD_O(SUBMAP_SELECT_FIELD_O));
